// ===== common/cicr_pkg.sv
// Package for the component input control register bank
package cicr_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_PORT_CLK = 8'h23;
  localparam logic [7:0] ADDR_CH3_GAIN = 8'h24;
  localparam logic [7:0] ADDR_CH4_GAIN = 8'h25;
  localparam logic [7:0] ADDR_SW_CTRL = 8'h29;
  // Field positions in the analog port and clock control register
  localparam int BIT_OUT_SEL2 = 7;
  localparam int BIT_PORT_OE = 6;
  localparam int BIT_CLK_SEL = 5;
  localparam int BIT_REF_SEL = 4;
  localparam int BIT_SRC_RST_EN = 2;
  localparam int BIT_CH4_MSB = 1;
  localparam int BIT_CH3_MSB = 0;
  // Field positions in the delay and switch control register
  localparam int BIT_SW_EN = 7;
  localparam int BIT_SW_POL = 6;
  localparam int BIT_DLY_HI = 5;
  localparam int BIT_DLY_LO = 4;
  // Writable bit masks; other bits read as zero
  localparam logic [7:0] MASK_PORT_CLK = 8'hF7;
  localparam logic [7:0] MASK_SW_CTRL = 8'hF0;
  // Reset values
  localparam logic [7:0] RST_PORT_CLK = 8'h00;
  localparam logic [7:0] RST_CH3_GAIN = 8'h90;
  localparam logic [7:0] RST_CH4_GAIN = 8'h90;
  localparam logic [7:0] RST_SW_CTRL = 8'h00;
  // Pixel switch delay codes
  localparam logic [1:0] DLY_ZERO = 2'h0;
  localparam logic [1:0] DLY_PLUS1 = 2'h1;
  localparam logic [1:0] DLY_MINUS2 = 2'h2;
  localparam logic [1:0] DLY_MINUS1 = 2'h3;
  // Switch delay line length; zero-delay tap at SW_PIPE-2 is the base point for plus and minus shifts
  localparam int SW_PIPE = 4;

  // Register bus request
  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] addr;
    logic [7:0] wrData;
  } cicr_req_t;

  // Decoded configuration
  typedef struct packed {
    logic outSelBit2;
    logic portOutEnable;
    logic clockSelect;
    logic refSelect;
    logic srcResetEnable;
    logic [8:0] ch3Gain;
    logic [8:0] ch4Gain;
    logic switchEnable;
    logic switchPolarity;
    logic [1:0] switchDelay;
  } cicr_cfg_t;
endpackage : cicr_pkg

// ===== design/cicr_sync.sv
// Two flip-flop synchroniser for one level
`timescale 1ns/100ps
module cicr_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Data
  input wire logic asyncIn,
  output logic syncOut
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } cicr_sync_t;

  cicr_sync_t state_reg;
  cicr_sync_t state_next;

  always_comb begin
    state_next.stage1 = asyncIn;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stage2;
endmodule : cicr_sync

// ===== design/cicr_regs.sv
// Component input control registers and pixel fast switch
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R01] Port enable bit 0 releases raw converter port; 1 drives it.
// [R02] Clock select 0 picks line-locked clock; 1 picks external clock pin.
// [R03] Reference select 0 defers to clamp mode bit; 1 selects reference.
// [R04] When enabled, any edge on source switch input resets gain loop.
// [R05] Channel 3 gain: msb at 23h bit 0, low byte at 24h.
// [R06] Channel 4 gain: msb at 23h bit 1, low byte at 25h.
// [R07] Switch enable 1 selects composite or component per pixel.
// [R08] Host enables pixel switching only for sources synchronous to composite.
// [R09] Polarity 0: low input picks composite; polarity 1 inverts mapping.
// [R10] Delay code: 00 none, 01 plus one, 10 minus two, 11 minus one.
// [R11] Switch disabled: polarity bit is the static source selection.
// [R12] Switch input sampled once per pixel clock after delay; drives mux.
module cicr_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register access
  input wire cicr_pkg::cicr_req_t regReq,
  output logic [7:0] rdData,
  // Front end inputs
  input wire logic clampModeBit,
  input wire logic sourceSwitchIndicatorIn,
  input wire logic pixelSwitchInput,
  input wire logic [7:0] rawConverterData,
  // Front end outputs
  output cicr_pkg::cicr_cfg_t cfg,
  output logic [7:0] rawPortOut,
  output logic rawPortOe,
  output logic useExternalClock,
  output logic clampFollowsMode,
  output logic gainLoopReset,
  output logic selectComponent
);
  typedef struct packed {
    logic [7:0] portClk;
    logic [7:0] ch3Low;
    logic [7:0] ch4Low;
    logic [7:0] swCtrl;
    logic [7:0] rdData;
    logic srcPrev;
    logic [cicr_pkg::SW_PIPE-1:0] swPipe;
    logic [7:0] rawOut;
    logic rawOe;
    logic extClk;
    logic clampMode;
    logic gainReset;
    logic selComp;
  } cicr_state_t;

  cicr_state_t state_reg;
  cicr_state_t state_next;
  logic srcSync;
  logic swSync;
  logic delayedSw;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  cicr_sync u_src_sync (
    .clock(clock),
    .arst_n(arst_n),
    .asyncIn(sourceSwitchIndicatorIn),
    .syncOut(srcSync)
  );

  cicr_sync u_sw_sync (
    .clock(clock),
    .arst_n(arst_n),
    .asyncIn(pixelSwitchInput),
    .syncOut(swSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    if (regReq.wrStrobe) begin
      if (regReq.addr == cicr_pkg::ADDR_PORT_CLK) begin
        state_next.portClk = regReq.wrData & cicr_pkg::MASK_PORT_CLK;
      end else if (regReq.addr == cicr_pkg::ADDR_CH3_GAIN) begin
        state_next.ch3Low = regReq.wrData; // [R05]
      end else if (regReq.addr == cicr_pkg::ADDR_CH4_GAIN) begin
        state_next.ch4Low = regReq.wrData; // [R06]
      end else if (regReq.addr == cicr_pkg::ADDR_SW_CTRL) begin
        state_next.swCtrl = regReq.wrData & cicr_pkg::MASK_SW_CTRL;
      end
    end
    if (regReq.rdStrobe) begin
      if (regReq.addr == cicr_pkg::ADDR_PORT_CLK) begin
        state_next.rdData = state_reg.portClk;
      end else if (regReq.addr == cicr_pkg::ADDR_CH3_GAIN) begin
        state_next.rdData = state_reg.ch3Low;
      end else if (regReq.addr == cicr_pkg::ADDR_CH4_GAIN) begin
        state_next.rdData = state_reg.ch4Low;
      end else if (regReq.addr == cicr_pkg::ADDR_SW_CTRL) begin
        state_next.rdData = state_reg.swCtrl;
      end else begin
        state_next.rdData = 8'h00;
      end
    end
    // Port drive
    state_next.rawOe = state_reg.portClk[cicr_pkg::BIT_PORT_OE]; // [R01]
    state_next.rawOut = rawConverterData;
    state_next.extClk = state_reg.portClk[cicr_pkg::BIT_CLK_SEL]; // [R02]
    state_next.clampMode = !state_reg.portClk[cicr_pkg::BIT_REF_SEL] && clampModeBit; // [R03]
    // Edge on the indicator resets the gain loop for one cycle
    state_next.srcPrev = srcSync;
    state_next.gainReset = state_reg.portClk[cicr_pkg::BIT_SRC_RST_EN]
                           && (srcSync != state_reg.srcPrev); // [R04]
    // Switch delay line, one stage per pixel clock
    state_next.swPipe = {state_reg.swPipe[cicr_pkg::SW_PIPE-2:0], swSync}; // [R12]
    if (state_reg.swCtrl[cicr_pkg::BIT_SW_EN]) begin // [R07]
      state_next.selComp = delayedSw ^ state_reg.swCtrl[cicr_pkg::BIT_SW_POL]; // [R09]
    end else begin
      state_next.selComp = state_reg.swCtrl[cicr_pkg::BIT_SW_POL]; // [R11]
    end
  end

  // Delay tap: more pipeline means switch arrives later than component
  always_comb begin
    case (state_reg.swCtrl[cicr_pkg::BIT_DLY_HI:cicr_pkg::BIT_DLY_LO]) // [R10]
      cicr_pkg::DLY_PLUS1: delayedSw = state_reg.swPipe[cicr_pkg::SW_PIPE - 1];
      cicr_pkg::DLY_MINUS2: delayedSw = state_reg.swPipe[cicr_pkg::SW_PIPE - 4];
      cicr_pkg::DLY_MINUS1: delayedSw = state_reg.swPipe[cicr_pkg::SW_PIPE - 3];
      default: delayedSw = state_reg.swPipe[cicr_pkg::SW_PIPE - 2];
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.portClk <= cicr_pkg::RST_PORT_CLK;
      state_reg.ch3Low <= cicr_pkg::RST_CH3_GAIN;
      state_reg.ch4Low <= cicr_pkg::RST_CH4_GAIN;
      state_reg.swCtrl <= cicr_pkg::RST_SW_CTRL;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdData = state_reg.rdData;
  assign cfg.outSelBit2 = state_reg.portClk[cicr_pkg::BIT_OUT_SEL2];
  assign cfg.portOutEnable = state_reg.portClk[cicr_pkg::BIT_PORT_OE];
  assign cfg.clockSelect = state_reg.portClk[cicr_pkg::BIT_CLK_SEL];
  assign cfg.refSelect = state_reg.portClk[cicr_pkg::BIT_REF_SEL];
  assign cfg.srcResetEnable = state_reg.portClk[cicr_pkg::BIT_SRC_RST_EN];
  assign cfg.ch3Gain = {state_reg.portClk[cicr_pkg::BIT_CH3_MSB], state_reg.ch3Low}; // [R05]
  assign cfg.ch4Gain = {state_reg.portClk[cicr_pkg::BIT_CH4_MSB], state_reg.ch4Low}; // [R06]
  assign cfg.switchEnable = state_reg.swCtrl[cicr_pkg::BIT_SW_EN];
  assign cfg.switchPolarity = state_reg.swCtrl[cicr_pkg::BIT_SW_POL];
  assign cfg.switchDelay = state_reg.swCtrl[cicr_pkg::BIT_DLY_HI:cicr_pkg::BIT_DLY_LO];
  assign rawPortOut = state_reg.rawOut;
  assign rawPortOe = state_reg.rawOe;
  assign useExternalClock = state_reg.extClk;
  assign clampFollowsMode = state_reg.clampMode;
  assign gainLoopReset = state_reg.gainReset;
  assign selectComponent = state_reg.selComp;
endmodule : cicr_regs

// ===== bench/cicr_regs_chk.sv
// Assertion checker for the component input control registers
`timescale 1ns/100ps
module cicr_regs_chk (
  // Clock, reset and register access
  input wire logic clock,
  input wire logic arst_n,
  input wire cicr_pkg::cicr_req_t regReq,
  input wire logic [7:0] rdData,
  // Front end
  input wire logic clampModeBit,
  input wire logic sourceSwitchIndicatorIn,
  input wire logic pixelSwitchInput,
  input wire logic [7:0] rawConverterData,
  input wire cicr_pkg::cicr_cfg_t cfg,
  input wire logic [7:0] rawPortOut,
  input wire logic rawPortOe,
  input wire logic useExternalClock,
  input wire logic clampFollowsMode,
  input wire logic gainLoopReset,
  input wire logic selectComponent
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_oe; rawPortOe == $past(cfg.portOutEnable); endproperty
  a_oe: assert property (p_oe) else $error("port enable wrong");
  property p_clk; useExternalClock == $past(cfg.clockSelect); endproperty
  a_clk: assert property (p_clk) else $error("clock select wrong");
  property p_clamp; clampFollowsMode == $past(!cfg.refSelect && clampModeBit); endproperty
  a_clamp: assert property (p_clamp) else $error("clamp wrong");
  property p_raw; rawPortOut == $past(rawConverterData); endproperty
  a_raw: assert property (p_raw) else $error("raw port data wrong");
  property p_gain; cfg.srcResetEnable && $changed(sourceSwitchIndicatorIn)
    |-> ##[2:4] gainLoopReset; endproperty
  a_gain: assert property (p_gain) else $error("no gain reset");
  property p_wr24; regReq.wrStrobe && regReq.addr == cicr_pkg::ADDR_CH3_GAIN
    |=> cfg.ch3Gain[7:0] == $past(regReq.wrData); endproperty
  a_wr24: assert property (p_wr24) else $error("ch3 low wrong");
  property p_wr23; regReq.wrStrobe && regReq.addr == cicr_pkg::ADDR_PORT_CLK
    |=> {cfg.ch4Gain[8], cfg.ch3Gain[8]} == $past(regReq.wrData[1:0]); endproperty
  a_wr23: assert property (p_wr23) else $error("gain msb wrong");
  property p_swdyn; (cfg.switchEnable && $stable(cfg.switchPolarity)
    && $stable(pixelSwitchInput))[*8]
    |-> selectComponent == (pixelSwitchInput ^ cfg.switchPolarity); endproperty
  a_swdyn: assert property (p_swdyn) else $error("pixel select wrong");
  property p_swst; $past(!cfg.switchEnable)
    |-> selectComponent == $past(cfg.switchPolarity); endproperty
  a_swst: assert property (p_swst) else $error("static select wrong");
endmodule : cicr_regs_chk

// ===== bench/cicr_host.sv
// Host model driving the register strobe port
`timescale 1ns/100ps
module cicr_host (
  // Clock and register access
  input wire logic clock,
  output cicr_pkg::cicr_req_t regReq,
  input wire logic [7:0] rdData
);
  initial regReq = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regReq = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    regReq = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    regReq = '{1'b0, 1'b0, ~a, 8'hFF};
    d = rdData;
  endtask : rd
endmodule : cicr_host

// ===== bench/cicr_regs_test.sv
// Testbench for the component input control registers
`timescale 1ns/100ps
module cicr_regs_test;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic clampModeBit = 1'b0;
  logic srcInd = 1'b0;
  logic pixIn = 1'b0;
  logic [7:0] rawData = 8'h00;
  logic [7:0] rdData, rawPortOut, rv;
  logic rawPortOe, useExternalClock, clampFollowsMode, gainLoopReset, selectComponent;
  cicr_pkg::cicr_req_t regReq;
  cicr_pkg::cicr_cfg_t cfg;
  int err_count = 0;
  int n_checks = 0;
  int lat[4];
  always #5 clock = ~clock;
  cicr_host u_cicr_host (.clock(clock), .regReq(regReq), .rdData(rdData));
  cicr_regs u_cicr_regs (.clock(clock), .arst_n(arst_n), .regReq(regReq), .rdData(rdData),
    .clampModeBit(clampModeBit), .sourceSwitchIndicatorIn(srcInd), .pixelSwitchInput(pixIn),
    .rawConverterData(rawData), .cfg(cfg), .rawPortOut(rawPortOut), .rawPortOe(rawPortOe),
    .useExternalClock(useExternalClock), .clampFollowsMode(clampFollowsMode),
    .gainLoopReset(gainLoopReset), .selectComponent(selectComponent));
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_cicr_host.rd(a, rv);
    chk("read", 9'(e), 9'(rv));
  endtask : rchk
  task automatic t_regs;
    chk("ch3", 9'h090, cfg.ch3Gain);
    rchk(8'h23, 8'h00);
    rchk(8'h25, 8'h90);
    u_cicr_host.wr(8'h23, 8'hFF);
    u_cicr_host.wr(8'h24, 8'h00);
    u_cicr_host.wr(8'h25, 8'h5A);
    u_cicr_host.wr(8'h31, 8'hFF);
    rchk(8'h23, 8'hF7);
    rchk(8'h31, 8'h00);
    chk("ch3", 9'h100, cfg.ch3Gain);
    chk("ch4", 9'h15A, cfg.ch4Gain);
    chk("ref", 9'h001, 9'(cfg.refSelect));
    chk("srcen", 9'h001, 9'(cfg.srcResetEnable));
    rawData = 8'hA5;
    clampModeBit = 1'b1;
    @(negedge clock);
    chk("oe", 9'h001, 9'(rawPortOe));
    chk("raw", 9'h0A5, 9'(rawPortOut));
    chk("xclk", 9'h001, 9'(useExternalClock));
    chk("clamp", 9'h000, 9'(clampFollowsMode));
    u_cicr_host.wr(8'h23, 8'h00);
    @(negedge clock);
    chk("oe", 9'h000, 9'(rawPortOe));
    chk("xclk", 9'h000, 9'(useExternalClock));
    chk("clamp", 9'h001, 9'(clampFollowsMode));
    $display("registers done");
  endtask : t_regs
  task automatic t_gain;
    int n;
    u_cicr_host.wr(8'h23, 8'h04);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) u_cicr_host.wr(8'h23, 8'h00);
      n = 0;
      srcInd = ~srcInd;
      repeat (8) begin
        @(negedge clock);
        n += int'(gainLoopReset);
      end
      chk("pulses", 9'(k < 2), 9'(n));
    end
    $display("gain reset done");
  endtask : t_gain
  task automatic t_switch;
    int c;
    // Pin changes only on the pixel clock, so the source is synchronous
    for (int d = 0; d < 4; d++) begin
      u_cicr_host.wr(8'h29, 8'h80 | 8'(d << 4));
      pixIn = 1'b0;
      repeat (10) @(negedge clock);
      chk("sel", 9'h000, 9'(selectComponent));
      pixIn = 1'b1;
      c = 0;
      while (selectComponent !== 1'b1) begin
        @(negedge clock);
        c++;
        if (c > 20) begin
          chk("latency", 9'h014, 9'(c));
          return;
        end
      end
      lat[d] = c;
    end
    chk("d01", 9'h001, 9'(lat[1] - lat[0]));
    chk("d11", 9'h001, 9'(lat[0] - lat[3]));
    chk("d10", 9'h002, 9'(lat[0] - lat[2]));
    u_cicr_host.wr(8'h29, 8'hFF);
    rchk(8'h29, 8'hF0);
    chk("dly", 9'h003, 9'(cfg.switchDelay));
    repeat (10) @(negedge clock);
    chk("inv", 9'h000, 9'(selectComponent));
    pixIn = 1'b0;
    repeat (10) @(negedge clock);
    chk("inv", 9'h001, 9'(selectComponent));
    u_cicr_host.wr(8'h29, 8'h40);
    pixIn = 1'b1;
    repeat (10) @(negedge clock);
    chk("static", 9'h001, 9'(selectComponent));
    u_cicr_host.wr(8'h29, 8'h00);
    repeat (10) @(negedge clock);
    chk("static", 9'h000, 9'(selectComponent));
    $display("pixel switch done");
  endtask : t_switch
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    t_regs;
    t_gain;
    t_switch;
    report_and_stop;
  end
endmodule : cicr_regs_test
bind cicr_regs cicr_regs_chk u_cicr_regs_chk (.clock(clock), .arst_n(arst_n), .regReq(regReq),
  .rdData(rdData), .clampModeBit(clampModeBit),
  .sourceSwitchIndicatorIn(sourceSwitchIndicatorIn), .pixelSwitchInput(pixelSwitchInput),
  .rawConverterData(rawConverterData), .cfg(cfg), .rawPortOut(rawPortOut),
  .rawPortOe(rawPortOe), .useExternalClock(useExternalClock),
  .clampFollowsMode(clampFollowsMode), .gainLoopReset(gainLoopReset),
  .selectComponent(selectComponent));
